// ==== rtl/nand_guard_defines.svh ====
// constants for the nand command guard controller
// assumes an 8-bit nand i/o bus and 32-bit apb registers
`ifndef NAND_GUARD_DEFINES_SVH
`define NAND_GUARD_DEFINES_SVH
// register byte offsets
`define REG_CMD 12'h000
`define REG_STAT 12'h004
`define REG_IRQ 12'h008
`define REG_MASK 12'h00c
`define REG_DATA 12'h010
// command codes
`define CMD_STATUS 8'h70
`define CMD_STATUS_MP 8'h71
`define CMD_RESET 8'hff
`define CMD_READ 8'h00
`define CMD_SERIAL_IN 8'h80
`define CMD_COL_CHG 8'h85
`define CMD_PROG 8'h10
`define CMD_PROG_MP 8'h11
`define CMD_PROG_CACHE 8'h15
`define CMD_CACHE_READ 8'h31
`define CMD_ERASE_SETUP 8'h60
`define CMD_ERASE_GO 8'hd0
// status byte bit positions
`define SB_FAIL 0
`define SB_FAIL_PREV 1
`define SB_PB_READY 5
`define SB_DC_READY 6
`define SB_NOT_PROT 7
// last count of a strobe phase; each phase lasts four clocks
`define STROBE_CYC 4'h3
// irq bit positions
`define IRQ_DONE 0
`define IRQ_REFUSED 1
`define IRQ_FAIL 2
`endif

// ==== rtl/nand_guard_pkg.sv ====
// types for the nand command guard controller
// assumes nand_guard_defines.svh for numeric constants
package nand_guard_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    st_idle, st_cmd_set, st_cmd_hold, st_rd_low, st_rd_high
  } seq_type;
endpackage

// ==== rtl/nand_cmd_guard.sv ====
// host controller issuing guarded commands and status reads to nand
// assumes the nand i/o bus is joined by the bench from out/oe pairs
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "nand_guard_defines.svh"
module nand_cmd_guard
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // nand strobes
  output logic cmd_latch,
  output logic write_strobe_n,
  output logic read_strobe_n,
  output logic chip_enable_n,
  output logic write_protect_n,
  // nand i/o bus, enable low while driving
  input wire logic [7:0] io_in,
  output logic [7:0] io_out,
  output logic io_oe_n,
  input wire logic ready_busy_n,
  // interrupt
  output logic irq
);
  //////////////////////////////////////////////////////////////////////
  // state record
  typedef struct packed {
    nand_guard_pkg::seq_type st; // sequencer state
    logic [3:0] cnt; // strobe phase counter
    logic [7:0] cmd; // command being issued
    logic [7:0] last_cmd; // last command accepted
    logic serial_open; // serial data input in progress
    logic status_mode; // status output mode
    logic init_done; // first reset/status seen
    logic [7:0] status; // last status byte
    logic [7:0] data; // last read byte
    logic [2:0] irq_st; // sticky events
    logic [2:0] mask; // interrupt mask
    logic wp_n; // write protect drive
    logic [31:0] rdata; // apb read data
  } state_type;
  state_type q, d;
  logic wr_acc, rd_acc, allowed, known;
  //////////////////////////////////////////////////////////////////////
  // command filter
  always_comb
  begin
    wr_acc = psel && penable && pwrite;
    rd_acc = psel && penable && !pwrite;
    // only defined codes ever reach the pins
    case (pwdata[7:0])
      `CMD_STATUS, `CMD_STATUS_MP, `CMD_RESET, `CMD_READ,
      `CMD_SERIAL_IN, `CMD_COL_CHG, `CMD_PROG, `CMD_PROG_MP,
      `CMD_PROG_CACHE, `CMD_CACHE_READ, `CMD_ERASE_SETUP,
      `CMD_ERASE_GO: known = 1'b1;
      default: known = 1'b0;
    endcase
    allowed = known;
    // busy or still initialising: status and reset only, plus multi-plane status while busy once initialised
    if (!ready_busy_n || !q.init_done)
    begin
      allowed = (pwdata[7:0] == `CMD_STATUS) ||
                (pwdata[7:0] == `CMD_RESET) ||
                (ready_busy_n == 1'b0 && q.init_done &&
                 pwdata[7:0] == `CMD_STATUS_MP);
    end
    // during serial input only the listed follow-ups
    // other codes are refused so a program is never silently lost
    else if (q.serial_open)
    begin
      allowed = (pwdata[7:0] == `CMD_COL_CHG) ||
                (pwdata[7:0] == `CMD_PROG) ||
                (pwdata[7:0] == `CMD_PROG_MP) ||
                (pwdata[7:0] == `CMD_PROG_CACHE) ||
                (pwdata[7:0] == `CMD_RESET);
    end
  end
  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    d = q;
    d.cnt = q.cnt + 4'h1;
    case (q.st)
      nand_guard_pkg::st_idle:
      begin
        d.cnt = 4'h0;
        if (wr_acc && paddr == `REG_CMD && q.st == nand_guard_pkg::st_idle)
        begin
          if (allowed)
          begin
            d.cmd = pwdata[7:0];
            d.st = nand_guard_pkg::st_cmd_set;
          end
          else
            d.irq_st[`IRQ_REFUSED] = 1'b1;
        end
        else if (rd_acc && paddr == `REG_DATA)
          d.st = nand_guard_pkg::st_rd_low;
      end
      nand_guard_pkg::st_cmd_set:
        if (q.cnt == `STROBE_CYC)
        begin
          d.cnt = 4'h0;
          d.st = nand_guard_pkg::st_cmd_hold;
        end
      nand_guard_pkg::st_cmd_hold:
        if (q.cnt == `STROBE_CYC)
        begin
          d.st = nand_guard_pkg::st_idle;
          d.last_cmd = q.cmd;
          case (q.cmd)
            `CMD_STATUS, `CMD_STATUS_MP:
            begin
              d.status_mode = 1'b1;
              d.init_done = 1'b1;
            end
            `CMD_RESET:
            begin
              d.serial_open = 1'b0;
              d.status_mode = 1'b0;
              d.init_done = 1'b1;
            end
            `CMD_SERIAL_IN:
            begin
              // opens a page load; no page address leaves this block,
              // so ascending page order rests with the software
              d.serial_open = 1'b1;
              d.status_mode = 1'b0;
            end
            // column change keeps the page load open
            `CMD_COL_CHG: d.status_mode = 1'b0;
            `CMD_READ: d.status_mode = 1'b0;
            default:
            begin
              d.serial_open = 1'b0;
              d.status_mode = 1'b0;
            end
          endcase
          d.irq_st[`IRQ_DONE] = 1'b1;
        end
      nand_guard_pkg::st_rd_low:
        if (q.cnt == `STROBE_CYC)
        begin
          d.cnt = 4'h0;
          d.st = nand_guard_pkg::st_rd_high;
          if (q.status_mode)
          begin
            d.status = io_in;
            // fail counts on any status read once ready, as last_cmd is then always a status code
            if (io_in[`SB_DC_READY] && io_in[`SB_PB_READY] &&
                (io_in[`SB_FAIL] || io_in[`SB_FAIL_PREV]) &&
                q.last_cmd != `CMD_READ &&
                q.last_cmd != `CMD_CACHE_READ)
              d.irq_st[`IRQ_FAIL] = 1'b1;
          end
          else
            d.data = io_in;
        end
      nand_guard_pkg::st_rd_high:
        if (q.cnt == `STROBE_CYC)
          d.st = nand_guard_pkg::st_idle;
      default: d.st = nand_guard_pkg::st_idle;
    endcase
    // register writes
    if (wr_acc && paddr == `REG_IRQ)
      d.irq_st = d.irq_st & ~(pwdata[2:0] & ~(d.irq_st ^ q.irq_st));
    if (wr_acc && paddr == `REG_MASK)
      d.mask = pwdata[2:0];
    // bit 0 of a status word write drives protection
    if (wr_acc && paddr == `REG_STAT)
      d.wp_n = pwdata[0];
    // read mux
    case (paddr)
      `REG_STAT: d.rdata = {21'h00_0000, q.status_mode, q.serial_open,
                            ready_busy_n, q.status};
      `REG_IRQ: d.rdata = {29'h0000_0000, q.irq_st};
      `REG_MASK: d.rdata = {29'h0000_0000, q.mask};
      `REG_DATA: d.rdata = {24'h00_0000, q.status_mode ? q.status : q.data};
      default: d.rdata = 32'h0000_0000;
    endcase
  end
  //////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
    end
    else
      q <= d;
  end
  //////////////////////////////////////////////////////////////////////
  // outputs; data reads stall until the strobe cycle finishes
  always_comb
  begin
    pready = !(psel && penable) ||
             !(paddr == `REG_DATA && !pwrite) ||
             (q.st == nand_guard_pkg::st_rd_high && q.cnt == `STROBE_CYC);
    if (psel && penable && pwrite && paddr == `REG_CMD &&
        q.st != nand_guard_pkg::st_idle)
      pready = 1'b0;
    pslverr = 1'b0;
    // registered read word; a data read's byte is in it by the time
    // pready rises, so no path from the nand pins reaches prdata
    prdata = q.rdata;
    cmd_latch = (q.st == nand_guard_pkg::st_cmd_set) ||
                (q.st == nand_guard_pkg::st_cmd_hold);
    write_strobe_n = !(q.st == nand_guard_pkg::st_cmd_set);
    read_strobe_n = !(q.st == nand_guard_pkg::st_rd_low);
    chip_enable_n = (q.st == nand_guard_pkg::st_idle);
    write_protect_n = q.wp_n;
    io_out = q.cmd;
    io_oe_n = !cmd_latch;
    irq = |(q.irq_st & q.mask);
  end
endmodule

// ==== tb/nand_cmd_guard_properties.sv ====
// pin and apb checks for the nand guard controller
// assumes binding to nand_cmd_guard with its default codes
`timescale 1ns/10ps
`include "nand_guard_defines.svh"
module nand_cmd_guard_properties
(
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // nand side
  input wire logic cmd_latch,
  input wire logic chip_enable_n,
  input wire logic [7:0] io_out,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_protect_n,
  input wire logic ready_busy_n
);
  // accepted writes to command and status words
  wire acc = psel && penable && pready && pwrite;
  wire cw = acc && paddr == `REG_CMD;
  wire sw = acc && paddr == `REG_STAT;
  wire [7:0] c = pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // page load open: set by serial input on the pins, kept by column
  // change, closed by any other code that reaches the pins
  logic serial_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      serial_q <= 1'b0;
    else if ($rose(write_strobe_n) && cmd_latch)
      serial_q <= (io_out == `CMD_SERIAL_IN) ||
                  (serial_q && io_out == `CMD_COL_CHG);
  end
  ////////////////////////////////////////
  a_cmd_len: assert property ($fell(write_strobe_n) |->
    !write_strobe_n[*4] ##1 write_strobe_n) else $error("cmd pulse");
  a_rd_len: assert property ($fell(read_strobe_n) |->
    !read_strobe_n[*4] ##1 read_strobe_n) else $error("read pulse");
  a_cmd_phase: assert property (!write_strobe_n |-> cmd_latch)
    else $error("strobe without latch");
  a_rd_quiet: assert property (!read_strobe_n |-> !cmd_latch
    && write_strobe_n) else $error("read overlap");
  a_wp_reg: assert property (sw |=>
    write_protect_n == $past(pwdata[0])) else $error("wp stale");
  a_undef_cmd: assert property (cw && !(c inside {8'h70, 8'h71,
    8'hff, 8'h00, 8'h80, 8'h85, 8'h10, 8'h11, 8'h15, 8'h31, 8'h60,
    8'hd0}) |=> write_strobe_n[*8]) else $error("undefined sent");
  a_busy_cmd: assert property (cw && !ready_busy_n
    && !(c inside {8'h70, 8'h71, 8'hff})
    |=> write_strobe_n[*8]) else $error("busy sent");
  a_serial_cmd: assert property (cw && serial_q && ready_busy_n
    && !(c inside {8'h85, 8'h10, 8'h11, 8'h15, 8'hff})
    |=> write_strobe_n[*8]) else $error("serial follow-up sent");
  a_ce_active: assert property ((cmd_latch || !read_strobe_n)
    |-> !chip_enable_n) else $error("chip not enabled");
  a_data_wait: assert property ($rose(penable) && psel && !pwrite
    && paddr == `REG_DATA |-> ##[1:30] pready) else $error("data hang");
  // main scenarios reached
  c_cmd: cover property (cw);
  c_read: cover property ($fell(read_strobe_n));
  c_busy: cover property (cw && !ready_busy_n);
endmodule
bind nand_cmd_guard nand_cmd_guard_properties chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .cmd_latch(cmd_latch),
  .chip_enable_n(chip_enable_n), .io_out(io_out),
  .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
  .write_protect_n(write_protect_n), .ready_busy_n(ready_busy_n));

// ==== tb/nand_flash_model.sv ====
// behavioural flash device answering the controller strobes
// assumes the bench merges the i/o bus by output enable
`timescale 1ns/10ps
module nand_flash_model #(parameter int busy_len = 200)
(
  // host strobes
  input wire logic pclk,
  input wire logic cmd_latch,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic write_protect_n,
  input wire logic [7:0] io_out,
  // device answers
  output logic [7:0] io_in,
  output logic ready_busy_n
);
  int busy_q = busy_len; // power-on busy
  logic stat_mode_q = 1'b0;
  logic [7:0] last_q = 8'h00;
  // both ready bits equal, pass bits clear, unused bits zero
  wire [7:0] stat = {write_protect_n,
    {2{busy_q == 0}}, 5'h00};
  // driven directly, not open drain: high once the busy timer has counted down to zero
  assign ready_busy_n = busy_q == 0;
  // released bus shows the inverse of the last byte, never a stale copy
  assign io_in = read_strobe_n ? ~last_q : last_q;
  ////////////////////////////////////////
  // internal operation timer
  always @(posedge pclk)
    if (busy_q > 0) busy_q <= busy_q - 1;
  // command decode on the rising write strobe
  always @(posedge write_strobe_n)
    if (cmd_latch)
    begin
      stat_mode_q <= io_out inside {8'h70, 8'h71};
      if (io_out == 8'hff) busy_q <= 2;
      if (io_out inside {8'h10, 8'h15, 8'hd0} && write_protect_n)
        busy_q <= busy_len;
    end
  // one byte per falling read strobe
  always @(negedge read_strobe_n)
    last_q <= stat_mode_q ? stat : 8'ha5;
endmodule

// ==== tb/nand_status_reset_command_guard_tb_top.sv ====
// self-checking bench for the nand command guard controller
// assumes the flash model on the far side of the strobes
`timescale 1ns/10ps
`include "nand_guard_defines.svh"
module nand_status_reset_command_guard_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic pready, pslverr, cl, wsn, rsn, cen, wpn, oen, rbn, irq;
  logic [7:0] ioi, ioo;
  int err_count = 0, n_checks = 0, cyc = 0;
  // rows: command code, then expected refused/done bits
  logic [9:0] rows [10] = '{{8'h80, 2'h2}, {8'hff, 2'h1}, {8'h70, 2'h1},
    {8'h80, 2'h1}, {8'h00, 2'h2}, {8'h85, 2'h1}, {8'h10, 2'h1},
    {8'h60, 2'h2}, {8'h70, 2'h1}, {8'h42, 2'h2}};
  // bus level from whoever drives it
  wire [7:0] bus = oen ? ioi : ioo;
  nand_cmd_guard uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_latch(cl),
    .write_strobe_n(wsn), .read_strobe_n(rsn), .chip_enable_n(cen),
    .write_protect_n(wpn), .io_in(bus), .io_out(ioo), .io_oe_n(oen),
    .ready_busy_n(rbn), .irq(irq));
  nand_flash_model #(.busy_len(200)) dev (.pclk(pclk), .cmd_latch(cl),
    .write_strobe_n(wsn), .read_strobe_n(rsn), .write_protect_n(wpn),
    .io_out(bus), .io_in(ioi), .ready_busy_n(rbn));
  initial forever #5 pclk = ~pclk;
  ////////////////////////////////////////
  task automatic chk(logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // issue a command, poll until done or refused
  task automatic cmd(logic [7:0] c, logic [1:0] e);
    apb(1, `REG_IRQ, 32'h0000_0007);
    apb(1, `REG_CMD, {24'h00_0000, c});
    r = 0;
    while (r[1:0] == 0) apb(0, `REG_IRQ, 0);
    chk(r[1:0], e);
  endtask
  task end_of_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      err_count++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1, `REG_STAT, 32'h0000_0001);
    apb(1, `REG_MASK, 32'h0000_0002);
    for (int i = 0; i < 10; i++)
      cmd(rows[i][9:2], rows[i][1:0]);
    @(negedge pclk);
    chk(irq, 1'b1);
    apb(1, `REG_IRQ, 32'h0000_0002);
    @(negedge pclk);
    chk(irq, 1'b0);
    while (rbn !== 1'b1) @(posedge pclk);
    apb(0, `REG_DATA, 0);
    chk(r[7:0], 8'he0);
    // pass bits clear, so no fail event may be flagged
    apb(0, `REG_IRQ, 0);
    chk(r[2], 1'b0);
    apb(1, `REG_STAT, 0);
    apb(0, `REG_DATA, 0);
    chk(r[7:0], 8'h60);
    cmd(8'h00, 2'h1);
    apb(0, `REG_DATA, 0);
    chk(r[7:0], 8'ha5);
    apb(0, 12'h100, 0);
    chk(r, 32'h0000_0000);
    chk(pslverr, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    @(negedge pclk);
    chk({wpn, oen, irq}, 3'h2);
    end_of_test();
  end
endmodule
